/* File: rtl/cdrcs_defs.svh */
// Register offsets, field positions, reset values and thresholds of the CDR register bank.
// Assumes inclusion by its bare name from the bank module.
`ifndef CDRCS_DEFS_SVH
`define CDRCS_DEFS_SVH

`define CDRCS_OFS_FREQ_LOW 8'h00
`define CDRCS_OFS_FREQ_MID 8'h01
`define CDRCS_OFS_FREQ_HIGH 8'h02
`define CDRCS_OFS_COARSE_RATE 8'h03
`define CDRCS_OFS_STATUS 8'h04
`define CDRCS_OFS_REF_CFG 8'h08
`define CDRCS_OFS_LOCK_RST 8'h09
`define CDRCS_OFS_SQUELCH 8'h11

`define CDRCS_CTRL_RESET 8'h00

`define CDRCS_REF_LOCK_BIT 0
`define CDRCS_REF_MEAS_BIT 1
`define CDRCS_REF_DIV_LSB 2
`define CDRCS_REF_DIV_MSB 5
`define CDRCS_REF_RANGE_LSB 6
`define CDRCS_REF_RANGE_MSB 7

`define CDRCS_LRC_CFG_LOL_BIT 7
`define CDRCS_LRC_CLR_STATIC_BIT 6
`define CDRCS_LRC_SYS_RST_BIT 5
`define CDRCS_LRC_CLR_MEAS_BIT 3

`define CDRCS_SQ_MODE_BIT 1

`define CDRCS_ST_STATIC_BIT 4
`define CDRCS_ST_LOL_BIT 3
`define CDRCS_ST_MEAS_BIT 2
`define CDRCS_ST_COARSE0_BIT 0

`define CDRCS_LOCK_LOSS_PPM 16'h03E8
`define CDRCS_LOCK_GAIN_PPM 16'h00FA
`define CDRCS_DIV_EXP_MAX 4'h8
`define CDRCS_DIV_RATIO_MAX 9'h100

`endif

/* File: rtl/cdrcs_pkg.sv */
// Types shared by the CDR register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package cdrcs_pkg;
	typedef logic [7:0] cdrcs_byte_t;
	typedef enum logic [2:0] {
		CDRCS_IDLE = 3'b000,
		CDRCS_ADDR = 3'b001,
		CDRCS_SUB = 3'b010,
		CDRCS_WDATA = 3'b011,
		CDRCS_ACK = 3'b100,
		CDRCS_TX = 3'b101,
		CDRCS_MACK = 3'b110
	} cdrcs_state_t;
endpackage

/* File: rtl/cdrcs_regs.sv */
// Control and status register bank of a continuous-rate clock and data recovery receiver, reached as an I2C slave.
// Assumes the recovery core shares clk_sys; SCL, SDA, the address strap and squelch are asynchronous pins.
`timescale 1ns/10ps

`include "cdrcs_defs.svh"

module cdrcs_regs #(
	parameter logic [6:0] SLAVE_ADDR = 7'h40, // Arbitrary base; bit 5 comes from the pin
	parameter int FREQ_W = 23,
	parameter int RATE_W = 9,
	parameter int PPM_W = 16
) (
	input wire logic clk_sys, // System clock, 125 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic scl_pin, // I2C clock pin
	input wire logic sda_in, // I2C data pin level
	output logic sda_out, // I2C data drive value, always low
	output logic sda_oe, // I2C data pull-down enable
	input wire logic slave_addr_bit5_pin, // Address strap
	input wire logic [FREQ_W-1:0] freq_count, // Frequency readback from core
	input wire logic [RATE_W-1:0] coarse_rate, // Coarse rate from core
	input wire logic [PPM_W-1:0] freq_err_ppm, // Oscillator to data error, ppm
	input wire logic meas_done, // Rate measurement finished pulse
	input wire logic squelch_pin, // Squelch request pin
	output logic lock_lost_flag, // Loss-of-lock pin
	output logic lock_to_ref, // Lock to reference clock
	output logic [1:0] reference_frequency, // Reference band code
	output logic [3:0] ref_div_exp, // Divider exponent
	output logic [8:0] divided_reference, // Divider ratio
	output logic meas_start, // Start rate measurement pulse
	output logic squelch_clk, // Blank recovered clock
	output logic squelch_data, // Blank recovered data
	output logic core_reset // Device reset pulse
);
	import cdrcs_pkg::*;

	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic scl_s;
	logic sda_s;
	logic scl_last_q;
	logic sda_last_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [6:0] own_addr;
	cdrcs_state_t state_q;
	cdrcs_state_t next_q;
	logic [3:0] bit_cnt_q;
	cdrcs_byte_t shift_q;
	cdrcs_byte_t sub_q;
	cdrcs_byte_t rd_byte;
	logic sda_oe_q;
	logic wr_stb_q;
	cdrcs_byte_t wr_addr_q;
	cdrcs_byte_t wr_data_q;
	cdrcs_byte_t ref_cfg_q;
	cdrcs_byte_t lock_rst_q;
	cdrcs_byte_t squelch_ctl_q;
	logic clr_static_q;
	logic clr_meas_q;
	logic sys_rst_q;
	logic meas_start_q;
	logic meas_complete_q;
	logic acquiring_q;
	logic acquiring_d;
	logic static_lol_q;
	logic lol_pin_q;
	logic lock_to_ref_q;
	logic [1:0] ref_range_q;
	logic [3:0] div_exp_q;
	logic [8:0] div_ratio_q;
	logic squelch_clk_q;
	logic squelch_data_q;
	logic core_reset_q;
	logic soft_rst;

	function automatic cdrcs_byte_t read_mux(input cdrcs_byte_t addr);
		cdrcs_byte_t r;
		r = 8'h00;
		if (addr == `CDRCS_OFS_FREQ_LOW) begin
			r = freq_count[7:0];
		end else if (addr == `CDRCS_OFS_FREQ_MID) begin
			r = freq_count[15:8];
		end else if (addr == `CDRCS_OFS_FREQ_HIGH) begin
			r = {1'b0, freq_count[22:16]};
		end else if (addr == `CDRCS_OFS_COARSE_RATE) begin
			r = coarse_rate[8:1];
		end else if (addr == `CDRCS_OFS_STATUS) begin
			r[`CDRCS_ST_STATIC_BIT] = static_lol_q;
			r[`CDRCS_ST_LOL_BIT] = acquiring_q;
			r[`CDRCS_ST_MEAS_BIT] = meas_complete_q;
			r[`CDRCS_ST_COARSE0_BIT] = coarse_rate[0];
		end
		return r;
	endfunction

	function automatic logic [8:0] div_ratio(input logic [3:0] n);
		logic [8:0] r;
		r = `CDRCS_DIV_RATIO_MAX;
		if (n < `CDRCS_DIV_EXP_MAX) begin
			r = 9'h001 << n;
		end
		return r;
	endfunction

	// Two-stage synchronisers for all pin inputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_q <= 4'hF;
			sync_q <= 4'hF;
		end else begin
			meta_q <= {scl_pin, sda_in, slave_addr_bit5_pin, squelch_pin};
			sync_q <= meta_q;
		end
	end

	assign scl_s = sync_q[3];
	assign sda_s = sync_q[2];
	assign own_addr = {SLAVE_ADDR[6], sync_q[1], SLAVE_ADDR[4:0]};

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			scl_last_q <= 1'b1;
			sda_last_q <= 1'b1;
		end else begin
			scl_last_q <= scl_s;
			sda_last_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_last_q;
	assign scl_fall = ~scl_s & scl_last_q;
	assign start_cond = scl_s & scl_last_q & sda_last_q & ~sda_s;
	assign stop_cond = scl_s & scl_last_q & ~sda_last_q & sda_s;
	assign rd_byte = read_mux(sub_q);

	// I2C slave: address, sub-address, write bytes, read bytes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= CDRCS_IDLE;
			next_q <= CDRCS_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			sub_q <= 8'h00;
			sda_oe_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
		end else begin
			wr_stb_q <= 1'b0;
			if (start_cond) begin
				state_q <= CDRCS_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (stop_cond) begin
				state_q <= CDRCS_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (state_q)
					CDRCS_ADDR, CDRCS_SUB, CDRCS_WDATA: begin
						if (scl_rise && bit_cnt_q != 4'h8) begin
							shift_q <= {shift_q[6:0], sda_s};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall && bit_cnt_q == 4'h8) begin
							bit_cnt_q <= 4'h0;
							state_q <= CDRCS_ACK;
							sda_oe_q <= 1'b1;
							if (state_q == CDRCS_ADDR) begin
								next_q <= shift_q[0] ? CDRCS_TX : CDRCS_SUB;
								if (shift_q[7:1] != own_addr) begin
									state_q <= CDRCS_IDLE;
									sda_oe_q <= 1'b0;
								end
							end else if (state_q == CDRCS_SUB) begin
								sub_q <= shift_q;
								next_q <= CDRCS_WDATA;
							end else begin
								wr_stb_q <= 1'b1;
								wr_addr_q <= sub_q;
								wr_data_q <= shift_q;
								sub_q <= sub_q + 8'h01;
								next_q <= CDRCS_WDATA;
							end
						end
					end
					CDRCS_ACK: begin
						if (scl_fall) begin
							state_q <= next_q;
							sda_oe_q <= 1'b0;
							if (next_q == CDRCS_TX) begin
								sda_oe_q <= ~rd_byte[7];
								shift_q <= {rd_byte[6:0], 1'b0};
								bit_cnt_q <= 4'h1;
								sub_q <= sub_q + 8'h01;
							end
						end
					end
					CDRCS_TX: begin
						if (scl_fall) begin
							if (bit_cnt_q == 4'h8) begin
								sda_oe_q <= 1'b0;
								bit_cnt_q <= 4'h0;
								state_q <= CDRCS_MACK;
							end else begin
								sda_oe_q <= ~shift_q[7];
								shift_q <= {shift_q[6:0], 1'b0};
								bit_cnt_q <= bit_cnt_q + 4'h1;
							end
						end
					end
					CDRCS_MACK: begin
						if (scl_rise && sda_s) begin
							state_q <= CDRCS_IDLE;
						end else if (scl_fall) begin
							state_q <= CDRCS_TX;
							sda_oe_q <= ~rd_byte[7];
							shift_q <= {rd_byte[6:0], 1'b0};
							bit_cnt_q <= 4'h1;
							sub_q <= sub_q + 8'h01;
						end
					end
					default: begin
						state_q <= CDRCS_IDLE;
					end
				endcase
			end
		end
	end

	assign soft_rst = sys_rst_q;

	// Write-only control registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n || soft_rst) begin
			ref_cfg_q <= `CDRCS_CTRL_RESET;
			lock_rst_q <= `CDRCS_CTRL_RESET;
			squelch_ctl_q <= `CDRCS_CTRL_RESET;
		end else if (wr_stb_q) begin
			if (wr_addr_q == `CDRCS_OFS_REF_CFG) begin
				ref_cfg_q <= wr_data_q;
			end else if (wr_addr_q == `CDRCS_OFS_LOCK_RST) begin
				lock_rst_q <= wr_data_q;
			end else if (wr_addr_q == `CDRCS_OFS_SQUELCH) begin
				squelch_ctl_q <= wr_data_q;
			end
		end
	end

	// Action pulses: clears and soft reset from a 1-then-0 write sequence, measure start from a single write of 1
	always_ff @(posedge clk_sys) begin
		if (!rst_n || soft_rst) begin
			clr_static_q <= 1'b0;
			clr_meas_q <= 1'b0;
			sys_rst_q <= 1'b0;
			meas_start_q <= 1'b0;
		end else begin
			clr_static_q <= wr_stb_q && wr_addr_q == `CDRCS_OFS_LOCK_RST
				&& lock_rst_q[`CDRCS_LRC_CLR_STATIC_BIT] && !wr_data_q[`CDRCS_LRC_CLR_STATIC_BIT];
			clr_meas_q <= wr_stb_q && wr_addr_q == `CDRCS_OFS_LOCK_RST
				&& lock_rst_q[`CDRCS_LRC_CLR_MEAS_BIT] && !wr_data_q[`CDRCS_LRC_CLR_MEAS_BIT];
			sys_rst_q <= wr_stb_q && wr_addr_q == `CDRCS_OFS_LOCK_RST
				&& lock_rst_q[`CDRCS_LRC_SYS_RST_BIT] && !wr_data_q[`CDRCS_LRC_SYS_RST_BIT];
			meas_start_q <= wr_stb_q && wr_addr_q == `CDRCS_OFS_REF_CFG && wr_data_q[`CDRCS_REF_MEAS_BIT];
		end
	end

	// Measurement complete flag; completion wins over a clear
	always_ff @(posedge clk_sys) begin
		if (!rst_n || soft_rst) begin
			meas_complete_q <= 1'b0;
		end else if (meas_done) begin
			meas_complete_q <= 1'b1;
		end else if (clr_meas_q || meas_start_q) begin
			meas_complete_q <= 1'b0;
		end
	end

	always_comb begin
		acquiring_d = acquiring_q;
		if (freq_err_ppm > `CDRCS_LOCK_LOSS_PPM) begin
			acquiring_d = 1'b1;
		end else if (freq_err_ppm <= `CDRCS_LOCK_GAIN_PPM) begin
			acquiring_d = 1'b0;
		end
	end

	// Lock detector with hysteresis and latched lock loss
	always_ff @(posedge clk_sys) begin
		if (!rst_n || soft_rst) begin
			acquiring_q <= 1'b1;
			static_lol_q <= 1'b0;
		end else begin
			acquiring_q <= acquiring_d;
			if (acquiring_d && !acquiring_q) begin
				static_lol_q <= 1'b1;
			end else if (clr_static_q) begin
				static_lol_q <= 1'b0;
			end
		end
	end

	// Registered outputs toward the core and pins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lol_pin_q <= 1'b1;
			lock_to_ref_q <= 1'b0;
			ref_range_q <= 2'h0;
			div_exp_q <= 4'h0;
			div_ratio_q <= 9'h001;
			squelch_clk_q <= 1'b0;
			squelch_data_q <= 1'b0;
			core_reset_q <= 1'b0;
		end else begin
			lol_pin_q <= lock_rst_q[`CDRCS_LRC_CFG_LOL_BIT] ? static_lol_q : acquiring_q;
			lock_to_ref_q <= ref_cfg_q[`CDRCS_REF_LOCK_BIT];
			ref_range_q <= ref_cfg_q[`CDRCS_REF_RANGE_MSB:`CDRCS_REF_RANGE_LSB];
			div_exp_q <= ref_cfg_q[`CDRCS_REF_DIV_MSB:`CDRCS_REF_DIV_LSB];
			div_ratio_q <= div_ratio(ref_cfg_q[`CDRCS_REF_DIV_MSB:`CDRCS_REF_DIV_LSB]);
			// Mode 1 leaves the clock running and blanks data only
			squelch_clk_q <= sync_q[0] & ~squelch_ctl_q[`CDRCS_SQ_MODE_BIT];
			squelch_data_q <= sync_q[0];
			core_reset_q <= sys_rst_q;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_q;
	assign lock_lost_flag = lol_pin_q;
	assign lock_to_ref = lock_to_ref_q;
	assign reference_frequency = ref_range_q;
	assign ref_div_exp = div_exp_q;
	assign divided_reference = div_ratio_q;
	assign meas_start = meas_start_q;
	assign squelch_clk = squelch_clk_q;
	assign squelch_data = squelch_data_q;
	assign core_reset = core_reset_q;
endmodule

/* File: test/cdrcs_regs_chk.sv */
// Pin-level checker of the CDR register bank.
// Assumes it is bound to every cdrcs_regs instance.
`timescale 1ns/10ps
module cdrcs_regs_chk #(
	parameter int PPM_W = 16
) (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic sda_out, // SDA drive value
	input wire logic sda_oe, // SDA pull enable
	input wire logic [PPM_W-1:0] freq_err_ppm, // Frequency error
	input wire logic squelch_pin, // Squelch request
	input wire logic lock_lost_flag, // Loss-of-lock pin
	input wire logic lock_to_ref, // Lock target
	input wire logic [1:0] reference_frequency, // Band code
	input wire logic [3:0] ref_div_exp, // Divider exponent
	input wire logic [8:0] divided_reference, // Divider ratio
	input wire logic meas_start, // Measure pulse
	input wire logic squelch_clk, // Clock blank
	input wire logic squelch_data, // Data blank
	input wire logic core_reset // Soft reset pulse
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_reset_values: assert property ($rose(rst_n) |-> lock_lost_flag && !lock_to_ref && !sda_oe
		&& reference_frequency == 2'h0 && ref_div_exp == 4'h0 && divided_reference == 9'h001 && !meas_start)
		else $error("outputs not at reset values");
	a_div_ratio: assert property (
		divided_reference == (ref_div_exp >= 4'h8 ? 9'h100 : 9'h001 << ref_div_exp))
		else $error("divider ratio does not match exponent");
	a_lol_assert: assert property (freq_err_ppm > 16'h03E8 |-> ##[2:3] lock_lost_flag)
		else $error("lock loss not shown above threshold");
	a_lol_hyst: assert property (
		freq_err_ppm > 16'h03E8 ##1 (freq_err_ppm > 16'h00FA) [*4] |-> lock_lost_flag)
		else $error("lock loss dropped above lower threshold");
	a_meas_pulse: assert property (meas_start |=> !meas_start)
		else $error("measure start longer than one cycle");
	a_soft_reset: assert property (core_reset |=> !core_reset ##[0:2] (!lock_to_ref && reference_frequency == 2'h0))
		else $error("soft reset did not clear control");
	a_squelch_pair: assert property (squelch_clk |-> squelch_data)
		else $error("clock blanked without data");
	a_squelch_idle: assert property ((!squelch_pin) [*5] |-> !squelch_clk && !squelch_data)
		else $error("blanking without squelch request");
	a_open_drain: assert property (!sda_out)
		else $error("SDA driven high");
endmodule
bind cdrcs_regs cdrcs_regs_chk #(.PPM_W(PPM_W)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sda_out(sda_out),
	.sda_oe(sda_oe), .freq_err_ppm(freq_err_ppm), .squelch_pin(squelch_pin), .lock_lost_flag(lock_lost_flag),
	.lock_to_ref(lock_to_ref), .reference_frequency(reference_frequency), .ref_div_exp(ref_div_exp),
	.divided_reference(divided_reference), .meas_start(meas_start), .squelch_clk(squelch_clk),
	.squelch_data(squelch_data), .core_reset(core_reset));

/* File: test/cdrcs_host.sv */
// I2C bus master model standing for the host controller.
// Assumes an SDA wire with pull-up; bit phases paced by clk_sys.
`timescale 1ns/10ps
module cdrcs_host (
	input wire logic clk_sys, // System clock
	input wire logic sda, // SDA wire level
	output logic scl, // SCL drive
	output logic sda_pull // High pulls SDA low
);
	logic acked; // Every byte sent acknowledged
	logic [7:0] rbuf [0:7]; // Bytes read
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		acked = 1'b1;
	end
	task hw(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task bit_io(input logic b, output logic r);
		sda_pull = !b;
		hw(4);
		scl = 1'b1;
		hw(7);
		r = sda;
		hw(1);
		scl = 1'b0;
		hw(4);
	endtask
	task start();
		sda_pull = 1'b0;
		scl = 1'b1;
		hw(8);
		sda_pull = 1'b1;
		hw(8);
		scl = 1'b0;
		hw(4);
	endtask
	task stop();
		sda_pull = 1'b1;
		hw(4);
		scl = 1'b1;
		hw(8);
		sda_pull = 1'b0;
		hw(8);
	endtask
	task send(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		if (r !== 1'b0) begin
			acked = 1'b0;
		end
	endtask
	task recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
	task write(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] dat);
		acked = 1'b1;
		start();
		send({dev, 1'b0});
		send(sub);
		send(dat);
		stop();
	endtask
	task read(input logic [6:0] dev, input logic [7:0] sub, input int n);
		acked = 1'b1;
		start();
		send({dev, 1'b0});
		send(sub);
		stop();
		start();
		send({dev, 1'b1});
		for (int i = 0; i < n; i++) begin
			recv(i == n - 1, rbuf[i]);
		end
		stop();
	endtask
endmodule

/* File: test/cdrcs_regs_test.sv */
// Self-checking bench of the CDR register bank.
// Assumes the host model on the I2C pins and the bound checker.
`timescale 1ns/10ps
module cdrcs_regs_test;
	typedef struct {logic [7:0] v; logic [1:0] band; logic [3:0] ex; logic lk;} cdrcs_row_t;
	cdrcs_row_t rows [5] = '{'{8'h04, 2'h0, 4'h1, 1'b0}, '{8'h48, 2'h1, 4'h2, 1'b0},
		'{8'h81, 2'h2, 4'h0, 1'b1}, '{8'hE0, 2'h3, 4'h8, 1'b0}, '{8'h3D, 2'h0, 4'hF, 1'b1}};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic slave_addr_bit5_pin = 1'b0;
	logic [22:0] freq_count = 23'h7FA5C3;
	logic [8:0] coarse_rate = 9'h1A7;
	logic [15:0] freq_err_ppm = 16'h0000;
	logic meas_done = 1'b0;
	logic squelch_pin = 1'b0;
	wire logic scl, sda_pull, sda, sda_out, sda_oe, lock_lost_flag, lock_to_ref;
	wire logic meas_start, squelch_clk, squelch_data, core_reset;
	wire logic [1:0] reference_frequency;
	wire logic [3:0] ref_div_exp;
	wire logic [8:0] divided_reference;
	int fail_count = 0;
	int checks_done = 0;
	int ms_cnt = 0;
	int cr_cnt = 0;
	assign sda = !(sda_oe && !sda_out) && !sda_pull;
	always #4 clk_sys = !clk_sys;
	always @(posedge clk_sys) begin
		if (meas_start === 1'b1) ms_cnt <= ms_cnt + 1;
		if (core_reset === 1'b1) cr_cnt <= cr_cnt + 1;
	end
	cdrcs_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .slave_addr_bit5_pin(slave_addr_bit5_pin), .freq_count(freq_count),
		.coarse_rate(coarse_rate), .freq_err_ppm(freq_err_ppm), .meas_done(meas_done), .squelch_pin(squelch_pin),
		.lock_lost_flag(lock_lost_flag), .lock_to_ref(lock_to_ref), .reference_frequency(reference_frequency),
		.ref_div_exp(ref_div_exp), .divided_reference(divided_reference), .meas_start(meas_start),
		.squelch_clk(squelch_clk), .squelch_data(squelch_data), .core_reset(core_reset));
	cdrcs_host i_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_pull(sda_pull));
	task hw(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task wr(input logic [7:0] s, input logic [7:0] d);
		i_host.write(7'h40, s, d);
		check(i_host.acked, 1'b1, "write not acknowledged");
		hw(4);
	endtask
	task st(input logic [7:0] mask, input logic [7:0] exp);
		i_host.read(7'h40, 8'h04, 1);
		check(i_host.rbuf[0] & mask, exp, "status byte");
	endtask
	task end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#320000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_of_test();
	end
	initial begin
		hw(20);
		check({lock_lost_flag, lock_to_ref, reference_frequency, ref_div_exp}, 8'h80, "reset outputs");
		rst_n = 1'b1;
		hw(4);
		check({lock_lost_flag, lock_to_ref, reference_frequency, ref_div_exp}, 8'h00, "locked after release");
		for (int i = 0; i < 5; i++) begin
			wr(8'h08, rows[i].v);
			check({lock_to_ref, reference_frequency}, {rows[i].lk, rows[i].band}, "lock target and band");
			check(ref_div_exp, rows[i].ex, "divider exponent");
			check(divided_reference, rows[i].ex >= 4'h8 ? 9'h100 : 9'h001 << rows[i].ex, "divider ratio");
		end
		i_host.read(7'h40, 8'h08, 1);
		check(i_host.rbuf[0], 8'h00, "write-only readback");
		i_host.read(7'h40, 8'h00, 6);
		check({i_host.rbuf[2], i_host.rbuf[1], i_host.rbuf[0]}, 24'h7FA5C3, "frequency bytes");
		check({i_host.rbuf[3], i_host.rbuf[4] & 8'h1D, i_host.rbuf[5]}, 24'hD30100, "rate, status, unmapped");
		wr(8'h08, 8'h02);
		check(ms_cnt, 1, "measure start pulses");
		st(8'h04, 8'h00);
		meas_done = 1'b1;
		hw(1);
		meas_done = 1'b0;
		st(8'h04, 8'h04);
		wr(8'h09, 8'h08);
		wr(8'h09, 8'h00);
		st(8'h04, 8'h00);
		freq_err_ppm = 16'h07D0;
		hw(4);
		check(lock_lost_flag, 1'b1, "lock loss live");
		st(8'h18, 8'h18);
		freq_err_ppm = 16'h00FA;
		hw(4);
		check(lock_lost_flag, 1'b0, "relock at lower threshold");
		st(8'h18, 8'h10);
		freq_err_ppm = 16'h03E8;
		hw(4);
		check(lock_lost_flag, 1'b0, "no loss at upper threshold");
		wr(8'h09, 8'h80);
		check(lock_lost_flag, 1'b1, "latched indication shown");
		wr(8'h09, 8'hC0);
		wr(8'h09, 8'h80);
		check(lock_lost_flag, 1'b0, "latch cleared");
		freq_err_ppm = 16'h03E9;
		hw(4);
		freq_err_ppm = 16'h00FA;
		hw(4);
		check(lock_lost_flag, 1'b1, "latch holds after relock");
		wr(8'h09, 8'h00);
		check(lock_lost_flag, 1'b0, "live indication restored");
		squelch_pin = 1'b1;
		hw(6);
		check({squelch_clk, squelch_data}, 2'b11, "squelch both");
		wr(8'h11, 8'h02);
		check({squelch_clk, squelch_data}, 2'b01, "squelch one");
		squelch_pin = 1'b0;
		hw(6);
		check({squelch_clk, squelch_data}, 2'b00, "squelch off");
		wr(8'h08, 8'hC1);
		wr(8'h09, 8'h20);
		wr(8'h09, 8'h00);
		check({cr_cnt[3:0], lock_to_ref, reference_frequency}, 7'h08, "soft reset");
		slave_addr_bit5_pin = 1'b1;
		hw(4);
		i_host.write(7'h40, 8'h08, 8'h01);
		check({i_host.acked, lock_to_ref}, 2'b00, "old address refused");
		i_host.write(7'h60, 8'h08, 8'h01);
		check({i_host.acked, lock_to_ref}, 2'b11, "strapped address taken");
		rst_n = 1'b0;
		hw(4);
		rst_n = 1'b1;
		hw(4);
		check(lock_to_ref, 1'b0, "reset in mid-run");
		end_of_test();
	end
endmodule
